// [core_program_flow_control.v]
// Sequencer, instruction pointer, flag sets and stack of the controller core.
//
// What this block does
// R1: Pins select programming (12 V supply), reset or working mode.
// R2: Five decoders: load, arithmetic, jump, control, fuzzy; collector merges outputs.
// R3: Arbiter enables exactly one decoder per instruction of groups 0-4 in working mode; groups 5-7 enable none.
// R4: Execution takes 6 to 26 clock pulses.
// R5: Instruction pointer is 12 bits, addressing 4096 program bytes.
// R6: Each program read writes the incremented pointer back.
// R7: Pointer loads branch target, vector, call address, reset vector, or popped value.
// R8: Two flag sets, normal and interrupt; active set follows current mode.
// R9: Taking an interrupt switches flag use to the interrupt set.
// R10: Interrupt exit restores saved flag set; normal context restores normal flags.
// R11: Call and subroutine exit run in normal mode; exit leaves flags unchanged.
// R12: Flags are never cleared on context switch.
// R13: Arithmetic overflow sets carry, else carry clears.
// R14: Arithmetic underflow sets sign, else sign clears.
// R15: Separate spaces: RAM 128, inputs 18, outputs 9, configuration 17, program 4K.
// R16: Stack lives in RAM, two bytes per level, from address 127.
// R17: Stack pointer marks first free level; call or interrupt pushes pointer and flags.
// R18: Interrupt exit reloads pointer and flags from highest occupied level.
// R19: Input fetch copies selected input register into named RAM location.
// R20: Input index 0 stack pointer, 1-8 converter, 9-17 ports and timers.
// R21: Execution time is listed cycles plus three decode pulses.
// R22: Stack pointer moves down two per push, up two per pop; reset to top.
`timescale 1ns/10ps
`default_nettype none
`include "flow_consts.vh"
module core_program_flow_control
#(
  parameter PTR_W = 12
)
(
  // Clock and reset
  input  wire              core_clk,
  input  wire              resetn,
  // Mode control pins
  input  wire              reset_pin,
  input  wire              test_pin,
  input  wire              prog_supply_high,
  // Program memory
  output wire [PTR_W-1:0]  prog_addr,
  output reg               prog_rd,
  input  wire [7:0]        prog_data,
  // Instruction request from the fetch decoder
  input  wire              instr_valid,
  input  wire [2:0]        instr_group,
  input  wire [2:0]        flow_op,
  input  wire [4:0]        exec_cycles,
  input  wire [PTR_W-1:0]  target_addr,
  input  wire [6:0]        ram_dest,
  input  wire [4:0]        input_index,
  output reg               instr_done,
  // Interrupt request
  input  wire              irq_req,
  input  wire [PTR_W-1:0]  irq_vector,
  output reg               irq_ack,
  // Arithmetic flag update from the datapath unit
  input  wire              arith_update,
  input  wire              arith_overflow,
  input  wire              arith_underflow,
  input  wire              arith_zero,
  // Data RAM port
  output reg               ram_we,
  output reg  [6:0]        ram_addr,
  output reg  [7:0]        ram_wdata,
  output reg               ram_rd,
  input  wire [7:0]        ram_rdata,
  // Peripheral input sources
  input  wire [63:0]       adc_results,
  input  wire [23:0]       pin_inputs,
  input  wire [47:0]       timer_words,
  // Collected decoder enables and mode status
  output reg  [4:0]        group_enable,
  output wire [2:0]        active_flags,
  output reg               irq_mode_reg,
  output wire              prog_mode,
  output wire              work_mode,
  output wire [7:0]        stack_top_index
);

  // ------------------------------------------------------------
  // Mode pin synchronisers and mode decode
  // ------------------------------------------------------------
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;

  // Two-stage capture of the mode pins.
  always @(posedge core_clk)
  begin
    if (!resetn)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= {prog_supply_high, test_pin, reset_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Mode table: programming, reset or working.
  assign prog_mode = ~pin_sync_reg[0] & ~pin_sync_reg[1] & pin_sync_reg[2];  // R1
  assign work_mode = pin_sync_reg[0] & ~pin_sync_reg[1] & ~pin_sync_reg[2];  // R1

  // ------------------------------------------------------------
  // State machine
  // ------------------------------------------------------------
  localparam S_IDLE  = 6'b000001;
  localparam S_EXEC  = 6'b000010;
  localparam S_PUSH0 = 6'b000100;
  localparam S_PUSH1 = 6'b001000;
  localparam S_POP0  = 6'b010000;
  localparam S_POP1  = 6'b100000;

  reg [5:0]       state_reg;
  reg [PTR_W-1:0] ip_reg;
  reg [6:0]       sp_reg;
  reg [2:0]       normal_flags_reg;
  reg [2:0]       irq_flags_reg;
  reg [4:0]       cycle_cnt_reg;
  reg [2:0]       op_reg;
  reg [PTR_W-1:0] target_reg;
  reg             push_irq_reg;
  reg             fetch_pending_reg;
  reg [6:0]       dest_reg;
  reg [7:0]       pop_low_reg;
  wire [7:0]      input_word;

  assign prog_addr = ip_reg;
  // Current stack index, the same value that input entry 0 returns.
  assign stack_top_index = {1'b0, sp_reg};  // R20
  // Only the flag set of the current mode is visible.
  assign active_flags = irq_mode_reg ? irq_flags_reg : normal_flags_reg;  // R8

  // Input register bank reader.
  input_bank_mux u_input_bank
  (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .sel         (input_index),  // R15
    .stack_top   ({1'b0, sp_reg}),
    .adc_results (adc_results),
    .pin_inputs  (pin_inputs),
    .timer_words (timer_words),
    .rd_data     (input_word)
  );

  // Total pulses: listed cycles plus decode, clamped to the legal span.
  wire [5:0] total_raw;
  wire [4:0] total_pulses;
  assign total_raw = {1'b0, exec_cycles} + {1'b0, `DECODE_PULSES};  // R21
  assign total_pulses = (total_raw < {1'b0, `MIN_EXEC_PULSES}) ? `MIN_EXEC_PULSES :  // R4
                        (total_raw > {1'b0, `MAX_EXEC_PULSES}) ? `MAX_EXEC_PULSES :
                        total_raw[4:0];

  // Saved flag byte: mode bit plus current flags.
  wire [7:0] flag_byte;
  assign flag_byte = {4'h0, irq_mode_reg, active_flags};

  // Main sequencing process.
  always @(posedge core_clk)
  begin
    if (!resetn || !work_mode)
    begin
      state_reg         <= S_IDLE;
      ip_reg            <= `RESET_VECTOR;  // R7
      sp_reg            <= `RAM_TOP;  // R22
      normal_flags_reg  <= 3'h0;
      irq_flags_reg     <= 3'h0;
      irq_mode_reg      <= 1'b0;
      cycle_cnt_reg     <= 5'h00;
      op_reg            <= `OP_SEQ;
      target_reg        <= {PTR_W{1'b0}};
      push_irq_reg      <= 1'b0;
      fetch_pending_reg <= 1'b0;
      dest_reg          <= 7'h00;
      pop_low_reg       <= 8'h00;
      group_enable      <= 5'h00;
      instr_done        <= 1'b0;
      irq_ack           <= 1'b0;
      prog_rd           <= 1'b0;
      ram_we            <= 1'b0;
      ram_rd            <= 1'b0;
      ram_addr          <= 7'h00;
      ram_wdata         <= 8'h00;
    end
    else
    begin
      instr_done <= 1'b0;
      irq_ack    <= 1'b0;
      prog_rd    <= 1'b0;
      ram_we     <= 1'b0;
      ram_rd     <= 1'b0;
      // Flag updates go to the set of the current mode.
      if (arith_update)
      begin
        if (irq_mode_reg)  // R9
        begin
          irq_flags_reg[`FLAG_C] <= arith_overflow;  // R13
          irq_flags_reg[`FLAG_S] <= arith_underflow;  // R14
          irq_flags_reg[`FLAG_Z] <= arith_zero;
        end
        else
        begin
          normal_flags_reg[`FLAG_C] <= arith_overflow;  // R13
          normal_flags_reg[`FLAG_S] <= arith_underflow;  // R14
          normal_flags_reg[`FLAG_Z] <= arith_zero;
        end
      end
      case (state_reg)
        S_IDLE:
        begin
          group_enable <= 5'h00;
          if (irq_req && !irq_mode_reg)
          begin
            // Take the interrupt: save pointer and flags, then vector.
            push_irq_reg <= 1'b1;
            target_reg   <= irq_vector;
            irq_ack      <= 1'b1;
            state_reg    <= S_PUSH0;  // R17
          end
          else if (instr_valid)
          begin
            // Arbiter: one-hot enable of exactly one decoder for groups 0-4, none for groups 5-7.
            group_enable  <= 5'h01 << instr_group;  // R2 R3
            op_reg        <= flow_op;
            target_reg    <= target_addr;
            dest_reg      <= ram_dest;
            cycle_cnt_reg <= total_pulses - 5'h01;
            prog_rd       <= 1'b1;
            ip_reg        <= ip_reg + {{(PTR_W-1){1'b0}}, 1'b1};  // R5 R6
            state_reg     <= S_EXEC;
          end
        end
        S_EXEC:
        begin
          if (cycle_cnt_reg != 5'h00)
            cycle_cnt_reg <= cycle_cnt_reg - 5'h01;
          else
          begin
            // The decoder stays enabled until its instruction is done.
            if (group_enable[`GRP_LOAD] && fetch_pending_reg == 1'b0 && input_index < `IR_COUNT)
            begin
              // Input register fetch writes the selected register into RAM.
              ram_we    <= 1'b1;  // R19
              ram_addr  <= dest_reg;
              ram_wdata <= input_word;  // R20
              instr_done <= 1'b1;
              group_enable <= 5'h00;
              state_reg  <= S_IDLE;
            end
            else if (op_reg == `OP_BRANCH)
            begin
              ip_reg     <= target_reg;  // R7
              instr_done <= 1'b1;
              group_enable <= 5'h00;
              state_reg  <= S_IDLE;
            end
            else if (op_reg == `OP_CALL)
            begin
              push_irq_reg <= 1'b0;  // R11
              state_reg    <= S_PUSH0;
            end
            else if (op_reg == `OP_SUB_EXIT || op_reg == `OP_IRQ_EXIT)
            begin
              // Read the low byte of the highest occupied level first.
              ram_rd    <= 1'b1;
              ram_addr  <= sp_reg + 7'h02;
              state_reg <= S_POP0;
            end
            else
            begin
              instr_done <= 1'b1;
              group_enable <= 5'h00;
              state_reg  <= S_IDLE;
            end
          end
        end
        S_PUSH0:
        begin
          // Low byte: pointer bits 7:0 at the free level.
          ram_we    <= 1'b1;
          ram_addr  <= sp_reg;  // R16 R17
          ram_wdata <= ip_reg[7:0];
          state_reg <= S_PUSH1;
        end
        S_PUSH1:
        begin
          // High byte: flags and pointer bits 11:8.
          ram_we    <= 1'b1;
          ram_addr  <= sp_reg - 7'h01;
          ram_wdata <= {flag_byte[3:0], ip_reg[PTR_W-1:8]};
          sp_reg    <= sp_reg - 7'h02;  // R22
          ip_reg    <= target_reg;  // R7
          if (push_irq_reg)
            irq_mode_reg <= 1'b1;  // R9 R12
          else
          begin
            // A call ends here; an interrupt continues at its vector.
            instr_done   <= 1'b1;
            group_enable <= 5'h00;
          end
          state_reg <= S_IDLE;
        end
        S_POP0:
        begin
          // Then the high byte with the saved flags and pointer bits 11:8.
          ram_rd    <= 1'b1;
          ram_addr  <= sp_reg + 7'h01;
          state_reg <= S_POP1;
        end
        S_POP1:
        begin
          if (!ram_rd)
          begin
            // Second byte arrived: rebuild pointer and maybe flags.
            ip_reg <= {ram_rdata[3:0], pop_low_reg};  // R7 R18
            sp_reg <= sp_reg + 7'h02;  // R22
            if (op_reg == `OP_IRQ_EXIT)
            begin
              irq_mode_reg <= ram_rdata[4 + `FLAG_MODE];  // R10
              if (ram_rdata[4 + `FLAG_MODE])
                irq_flags_reg <= ram_rdata[6:4];  // R18
              else
                normal_flags_reg <= ram_rdata[6:4];  // R10
            end
            instr_done <= 1'b1;
            group_enable <= 5'h00;
            state_reg  <= S_IDLE;
          end
          else
            // First byte arrived: hold the low pointer byte.
            pop_low_reg <= ram_rdata;
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// [core_program_flow_control_tb_top.sv]
// Self-checking testbench of the program-flow control block.
`timescale 1ns/10ps
`default_nettype none
`include "flow_consts.vh"
module core_program_flow_control_tb_top;
  logic        core_clk = 0, resetn = 0, reset_pin = 1, test_pin = 0, prog_supply_high = 0;
  logic        instr_valid = 0, irq_req = 0, arith_update = 0;
  logic        arith_overflow = 0, arith_underflow = 0, arith_zero = 0;
  logic [2:0]  instr_group = 0, flow_op = 0, active_flags, nf;
  logic [4:0]  exec_cycles = 0, input_index = 0, group_enable, idx;
  logic [11:0] target_addr = 0, irq_vector = 0, prog_addr, ip, ret, t;
  logic [6:0]  ram_dest = 0, ram_addr, d;
  logic [7:0]  ram_wdata, ram_rdata, stack_top_index;
  logic [63:0] adc_results = 0;
  logic [23:0] pin_inputs = 0;
  logic [47:0] timer_words = 0;
  logic        prog_rd, instr_done, irq_ack, irq_mode_reg, ram_we, ram_rd, prog_mode, work_mode;
  int          n_fail = 0, num_checks = 0, n, k, i, j, c;

  core_program_flow_control core_program_flow_control_inst
  (
    .core_clk(core_clk), .resetn(resetn), .reset_pin(reset_pin), .test_pin(test_pin),
    .prog_supply_high(prog_supply_high), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(8'hA5),
    .instr_valid(instr_valid), .instr_group(instr_group), .flow_op(flow_op), .exec_cycles(exec_cycles),
    .target_addr(target_addr), .ram_dest(ram_dest), .input_index(input_index), .instr_done(instr_done),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .arith_update(arith_update),
    .arith_overflow(arith_overflow), .arith_underflow(arith_underflow), .arith_zero(arith_zero),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rd(ram_rd), .ram_rdata(ram_rdata),
    .adc_results(adc_results), .pin_inputs(pin_inputs), .timer_words(timer_words),
    .group_enable(group_enable), .active_flags(active_flags), .irq_mode_reg(irq_mode_reg),
    .prog_mode(prog_mode), .work_mode(work_mode), .stack_top_index(stack_top_index)
  );

  data_ram_model data_ram_model_inst
  (
    .core_clk(core_clk), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rd(ram_rd), .ram_rdata(ram_rdata)
  );

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  // Prints the counts and the verdict, then stops.
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Compares a seen value against the expected one.
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  // Expected byte of an input bank entry above the stack index.
  function logic [7:0] bank(input int x);
    if (x < 9)
      bank = adc_results[8*(x-1) +: 8];
    else if (x < 12)
      bank = pin_inputs[8*(x-9) +: 8];
    else
      bank = timer_words[8*(x-12) +: 8];
  endfunction

  // Expected execution length: listed cycles plus decode, kept within the documented span.
  function int span(input int x);
    span = (x + 3 < 6) ? 6 : (x + 3 > 26) ? 26 : x + 3;
  endfunction

  // Issues one instruction, holds it until the fetch pulse and counts cycles to done.
  task run(input logic [2:0] g, input logic [2:0] op, input logic [4:0] cy, input logic [11:0] tg,
           input logic [6:0] ds, input logic [4:0] ix);
    begin
      @(posedge core_clk);
      {instr_valid, instr_group, flow_op, exec_cycles} <= {1'b1, g, op, cy};
      {target_addr, ram_dest, input_index} <= {tg, ds, ix};
      for (k = 0; k < 20 && prog_rd !== 1'b1; k++)
        @(posedge core_clk);
      instr_valid <= 1'b0;
      for (n = 0; n < 60 && instr_done !== 1'b1; n++)
        @(posedge core_clk);
      if (k == 20 || n == 60)
      begin
        n_fail++;
        end_of_test;
      end
      // One more edge lets the RAM model land the last write.
      @(posedge core_clk);
    end
  endtask

  // Raises an arithmetic flag update for one cycle.
  task flags(input logic o, input logic u, input logic z);
    begin
      @(posedge core_clk);
      {arith_update, arith_overflow, arith_underflow, arith_zero} <= {1'b1, o, u, z};
      @(posedge core_clk);
      arith_update <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // Main sequence.
  initial
  begin
    void'($urandom(32'h751066d0));
    adc_results = {$urandom, $urandom};
    pin_inputs = $urandom;
    timer_words = {$urandom, $urandom};
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    ip = `RESET_VECTOR;
    chk("reset pointer", prog_addr, ip);
    run(`GRP_LOAD, `OP_SEQ, 5'h0C, 12'h000, 7'h10, `IR_STACK_TOP);
    ip++;
    chk("stack index", data_ram_model_inst.mem[16], 8'h7F);
    chk("stack port", stack_top_index, 8'h7F);
    for (i = 0; i < 8; i++)
    begin
      idx = 1 + $urandom_range(16);
      d = $urandom_range(100);
      c = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(31);
      run(`GRP_LOAD, `OP_SEQ, c, 12'h000, d, idx);
      ip++;
      chk("exec span", n, span(c));
      chk("fetched byte", data_ram_model_inst.mem[d], bank(idx));
      chk("next pointer", prog_addr, ip);
    end
    flags(1, 0, 1);
    chk("carry set", active_flags, 3'b011);
    flags(0, 1, 0);
    chk("sign set", active_flags, 3'b100);
    nf = 3'b100;
    t = $urandom;
    run(`GRP_JUMP, `OP_BRANCH, 5'h05, t, 7'h00, 5'h00);
    ip = t;
    chk("branch", prog_addr, ip);
    t = $urandom;
    run(`GRP_JUMP, `OP_CALL, 5'h05, t, 7'h00, 5'h00);
    ret = ip + 1;
    chk("push low", data_ram_model_inst.mem[127], ret[7:0]);
    chk("push high", data_ram_model_inst.mem[126], {1'b0, nf, ret[11:8]});
    chk("call", prog_addr, t);
    chk("stack port", stack_top_index, 8'h7D);
    run(`GRP_LOAD, `OP_SEQ, 5'h05, 12'h000, 7'h11, `IR_STACK_TOP);
    chk("stack step", data_ram_model_inst.mem[17], 8'h7D);
    flags(1, 0, 0);
    nf = 3'b001;
    run(`GRP_CTRL, `OP_SUB_EXIT, 5'h05, 12'h000, 7'h00, 5'h00);
    ip = ret;
    chk("return", prog_addr, ip);
    chk("return flags", active_flags, nf);
    for (j = 0; j < 2; j++)
    begin
      t = $urandom;
      @(posedge core_clk);
      {irq_req, irq_vector} <= {1'b1, t};
      for (k = 0; k < 20 && irq_ack !== 1'b1; k++)
        @(posedge core_clk);
      if (k == 20)
      begin
        n_fail++;
        end_of_test;
      end
      irq_req <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("irq mode", irq_mode_reg, 1'b1);
      chk("irq flags", active_flags, j ? 3'b110 : 3'b000);
      chk("vector", prog_addr, t);
      irq_req <= 1'b1;
      for (c = 0, k = 0; k < 8; k++)
        @(posedge core_clk) c += (irq_ack === 1'b1);
      irq_req <= 1'b0;
      chk("nested refused", c, 0);
      flags(0, 1, 1);
      chk("irq flag write", active_flags, 3'b110);
      run(`GRP_CTRL, `OP_IRQ_EXIT, 5'h05, 12'h000, 7'h00, 5'h00);
      chk("normal mode", irq_mode_reg, 1'b0);
      chk("restored flags", active_flags, nf);
      chk("restored pointer", prog_addr, ip);
    end
    reset_pin <= 1'b0;
    prog_supply_high <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("program mode", {prog_mode, work_mode}, 2'b10);
    prog_supply_high <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("held reset", {prog_mode, work_mode}, 2'b00);
    reset_pin <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk("working mode", {prog_mode, work_mode, prog_addr}, {2'b01, `RESET_VECTOR});
    end_of_test;
  end
endmodule
`default_nettype wire

// [data_ram_model.sv]
// Data RAM partner model that holds the stack and fetched input bytes.
`timescale 1ns/10ps
`default_nettype none
module data_ram_model
(
  // Clock
  input  wire logic       core_clk,
  // RAM port
  input  wire logic       ram_we,
  input  wire logic [6:0] ram_addr,
  input  wire logic [7:0] ram_wdata,
  input  wire logic       ram_rd,
  output var  logic [7:0] ram_rdata
);
  logic [7:0] mem [0:127];

  // Writes land at the edge; a read answers next cycle, otherwise the bus keeps flipping.
  always @(posedge core_clk)
  begin
    if (ram_we)
      mem[ram_addr] <= ram_wdata;
    ram_rdata <= ram_rd ? mem[ram_addr] : ~ram_rdata;
  end

  // Start from a known bus value.
  initial
    ram_rdata = 8'h00;
endmodule
`default_nettype wire

// [flow_assertions.sv]
// Assertion checker bound to the program-flow control block.
`timescale 1ns/10ps
`default_nettype none
module flow_assertions
#(
  parameter PTR_W = 12
)
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       resetn,
  // Observed ports
  input wire logic       prog_rd,
  input wire logic       instr_done,
  input wire logic       irq_ack,
  input wire logic       irq_mode_reg,
  input wire logic       arith_update,
  input wire logic       arith_overflow,
  input wire logic       arith_underflow,
  input wire logic       arith_zero,
  input wire logic [4:0] group_enable,
  input wire logic [2:0] active_flags,
  input wire logic       prog_mode,
  input wire logic       work_mode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Decoder enables, mode decode, pulses and flag writes.
  chk_one_enable: assert property ($onehot0(group_enable))
    else $error("more than one decoder enabled");
  chk_idle_enable: assert property (!work_mode |=> group_enable == 5'h00)
    else $error("decoder enabled outside working mode");
  chk_mode_exclusive: assert property (!(prog_mode && work_mode))
    else $error("programming and working mode together");
  chk_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("done longer than one cycle");
  chk_min_exec: assert property (prog_rd |=> !instr_done [*5])
    else $error("instruction finished too early");
  chk_done_enabled: assert property ($rose(instr_done) |-> $past(group_enable) != 5'h00)
    else $error("instruction finished with no decoder enabled");
  chk_irq_flagset: assert property (irq_ack |=> !irq_ack ##1 irq_mode_reg)
    else $error("interrupt taken without interrupt mode");
  chk_no_nesting: assert property (irq_ack |-> !$past(irq_mode_reg))
    else $error("interrupt taken inside interrupt mode");
  chk_flag_write: assert property (arith_update |=>
    active_flags == {$past(arith_underflow), $past(arith_zero), $past(arith_overflow)})
    else $error("active flags do not follow arithmetic result");
endmodule

bind core_program_flow_control flow_assertions #(.PTR_W(PTR_W)) flow_assertions_inst
(
  .core_clk(core_clk), .resetn(resetn), .prog_rd(prog_rd), .instr_done(instr_done), .irq_ack(irq_ack),
  .irq_mode_reg(irq_mode_reg), .arith_update(arith_update), .arith_overflow(arith_overflow),
  .arith_underflow(arith_underflow), .arith_zero(arith_zero), .group_enable(group_enable),
  .active_flags(active_flags), .prog_mode(prog_mode), .work_mode(work_mode)
);
`default_nettype wire

// [flow_consts.vh]
// Constants for the program-flow control block.
`ifndef FLOW_CONSTS_VH
`define FLOW_CONSTS_VH
// Address widths and RAM layout.
`define PTR_W            12
`define RAM_AW           7
`define RAM_TOP          7'h7F
`define RESET_VECTOR     12'h000
// Decode overhead and execution length limits in clock pulses.
`define DECODE_PULSES    5'h03
`define MIN_EXEC_PULSES  5'h06
`define MAX_EXEC_PULSES  5'h1A
// Input register bank indices.
`define IR_STACK_TOP     5'h00
`define IR_ADC_CH0       5'h01
`define IR_ADC_CH7       5'h08
`define IR_PIN_A         5'h09
`define IR_PIN_B         5'h0A
`define IR_PIN_C         5'h0B
`define IR_TMR0_CNT      5'h0C
`define IR_TMR0_STAT     5'h0D
`define IR_TMR1_CNT      5'h0E
`define IR_TMR1_STAT     5'h0F
`define IR_TMR2_CNT      5'h10
`define IR_TMR2_STAT     5'h11
`define IR_COUNT         5'h12
// Instruction groups from the fetch decoder.
`define GRP_LOAD         3'h0
`define GRP_ARITH        3'h1
`define GRP_JUMP         3'h2
`define GRP_CTRL         3'h3
`define GRP_FUZZY        3'h4
// Flow operations within the jump and control groups.
`define OP_SEQ           3'h0
`define OP_BRANCH        3'h1
`define OP_CALL          3'h2
`define OP_SUB_EXIT      3'h3
`define OP_IRQ_EXIT      3'h4
// Flag bit positions within a saved flag byte.
`define FLAG_C           0
`define FLAG_Z           1
`define FLAG_S           2
`define FLAG_MODE        3
`endif

// [input_bank_mux.v]
// Read multiplexer of the peripheral input register bank.
`timescale 1ns/10ps
`default_nettype none
`include "flow_consts.vh"
module input_bank_mux
(
  // Clock and reset
  input  wire         core_clk,
  input  wire         resetn,
  // Selection
  input  wire [4:0]   sel,
  // Sources
  input  wire [7:0]   stack_top,
  input  wire [63:0]  adc_results,
  input  wire [23:0]  pin_inputs,
  input  wire [47:0]  timer_words,
  // Registered read data
  output reg  [7:0]   rd_data
);

  // Flat vector of all eighteen entries, index 0 in the low byte.
  wire [143:0] bank;
  assign bank = {timer_words, pin_inputs, adc_results, stack_top};

  // Registered selection; unmapped indices read as zero.
  always @(posedge core_clk)
  begin
    if (!resetn)
      rd_data <= 8'h00;
    else if (sel < `IR_COUNT)
      rd_data <= bank[sel*8 +: 8];
    else
      rd_data <= 8'h00;
  end

endmodule
`default_nettype wire
